// File: common/scwp_pkg.sv
package scwp_pkg;

  // frame layout, counted from the most significant bit of the 32-bit word
  localparam int unsigned FRAME_BITS = 32;
  localparam logic [4:0] LAST_BIT_IDX = 5'h1f;
  localparam int unsigned HDR_MSB = 31;
  localparam int unsigned HDR_LSB = 20;
  localparam int unsigned ADDR_MSB = 19;
  localparam int unsigned ADDR_LSB = 16;
  localparam int unsigned DATA_MSB = 15;
  localparam int unsigned DATA_LSB = 0;
  localparam logic [11:0] FRAME_HDR = 12'h001;

  // register addresses carried in the frame
  localparam logic [3:0] ADDR_CAL = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_OFS_A = 4'h2;
  localparam logic [3:0] ADDR_FS_A = 4'h3;
  localparam logic [3:0] ADDR_EXT_CFG = 4'h9;
  localparam logic [3:0] ADDR_OFS_B = 4'ha;
  localparam logic [3:0] ADDR_FS_B = 4'hb;
  localparam logic [3:0] ADDR_PH_FINE = 4'he;
  localparam logic [3:0] ADDR_PH_COARSE = 4'hf;

  // storage slots for the eight held registers
  localparam int unsigned NUM_REGS = 8;
  localparam logic [2:0] IDX_CFG = 3'h0;
  localparam logic [2:0] IDX_OFS_A = 3'h1;
  localparam logic [2:0] IDX_FS_A = 3'h2;
  localparam logic [2:0] IDX_EXT_CFG = 3'h3;
  localparam logic [2:0] IDX_OFS_B = 3'h4;
  localparam logic [2:0] IDX_FS_B = 3'h5;
  localparam logic [2:0] IDX_PH_FINE = 3'h6;
  localparam logic [2:0] IDX_PH_COARSE = 3'h7;

  // calibration register: trigger bit and its power-up value
  localparam int unsigned CAL_TRIG_BIT = 15;
  localparam logic [15:0] CAL_RST = 16'h7fff;

  // power-on values, slot 7 down to slot 0
  localparam logic [NUM_REGS-1:0][15:0] REG_RST = {
    16'h0000,  // coarse/intermediate phase: no adjustment
    16'h0000,  // fine phase: no adjustment
    16'h8000,  // full-scale, second channel
    16'h8000,  // offset, second channel
    16'h0000,  // extended configuration
    16'h8000,  // full-scale, first channel
    16'h8000,  // offset, first channel
    16'hb2ff   // configuration: ddr clocking, 1:2 demux
  };

  // whole state of the port
  typedef struct packed {
    logic sclk_prev;
    logic [31:0] shift;
    logic [4:0] cnt;
    logic [NUM_REGS-1:0][15:0] regs;
    logic [NUM_REGS-1:0][15:0] eff;
    logic wr;
    logic cal;
    logic hdr_err;
    logic rsv;
  } scwp_state_t;

endpackage

// File: rtl/scwp_sync.sv
`timescale 1ns/1ps

module scwp_sync
  import scwp_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } scwp_sync_t;

  scwp_sync_t s_reg;
  scwp_sync_t s_next;

  // ff1 only feeds ff2, so a metastable value never reaches logic
  always_comb begin
    s_next.ff1 = i_d;
    s_next.ff2 = s_reg.ff1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= {RST_VAL, RST_VAL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_q = s_reg.ff2;

endmodule

// File: rtl/scwp_top.sv
`timescale 1ns/1ps

module scwp_top
  import scwp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // mode pin: high selects extended control
  input wire logic i_ext_mode,
  // serial pins from the host
  input wire logic i_serial_clk,
  input wire logic i_serial_in_line,
  input wire logic i_serial_select_n,
  // configuration towards the converter
  output logic [15:0] o_cfg,
  output logic [15:0] o_ofs_a,
  output logic [15:0] o_fs_a,
  output logic [15:0] o_ext_cfg,
  output logic [15:0] o_ofs_b,
  output logic [15:0] o_fs_b,
  output logic [15:0] o_ph_fine,
  output logic [15:0] o_ph_coarse,
  // event pulses
  output logic o_cal_start,
  output logic o_wr_done,
  output logic o_hdr_err,
  output logic o_rsv_addr
);

  logic [3:0] pins_s;
  logic ext_s;
  logic sclk_s;
  logic sd_s;
  logic scs_n_s;
  logic active;
  logic rise;
  logic [31:0] frame_w;
  logic frame_done;
  logic frame_ok;
  logic [3:0] frame_addr;
  logic [15:0] frame_data;
  scwp_state_t st_reg;
  scwp_state_t st_next;

  // all four pins come from outside the clock domain
  scwp_sync #(
    .W(4),
    .RST_VAL(4'h1)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_ext_mode, i_serial_clk, i_serial_in_line, i_serial_select_n}),
    .o_q(pins_s)
  );

  assign ext_s = pins_s[3];
  assign sclk_s = pins_s[2];
  assign sd_s = pins_s[1];
  assign scs_n_s = pins_s[0];

  // framing terms; no minimum serial rate, edges are found by oversampling
  assign active = ext_s && !scs_n_s;
  assign rise = sclk_s && !st_reg.sclk_prev;
  assign frame_w = {st_reg.shift[30:0], sd_s};
  // the header is judged only once all 32 bits are in, so a bad frame still uses its 32 clocks
  assign frame_done = active && rise && (st_reg.cnt == LAST_BIT_IDX);
  assign frame_ok = frame_done && (frame_w[HDR_MSB:HDR_LSB] == FRAME_HDR);
  assign frame_addr = frame_w[ADDR_MSB:ADDR_LSB];
  assign frame_data = frame_w[DATA_MSB:DATA_LSB];

  // next state: shift, count, decode and store
  always_comb begin
    st_next = st_reg;
    st_next.sclk_prev = sclk_s;
    st_next.wr = 1'b0;
    st_next.cal = 1'b0;
    st_next.hdr_err = 1'b0;
    st_next.rsv = 1'b0;
    if (!active) begin
      // select high or normal mode: a partial frame is thrown away
      st_next.cnt = 5'h00;
    end else if (rise) begin
      st_next.shift = frame_w;
      st_next.cnt = st_reg.cnt + 5'h01;
      if (frame_done) begin
        // wraps to zero so the 33rd clock opens a new frame
        st_next.cnt = 5'h00;
      end
    end
    if (frame_done && !frame_ok) begin
      st_next.hdr_err = 1'b1;
    end
    if (frame_ok) begin
      st_next.wr = 1'b1;
      // registers change only here, so power-down leaves them intact
      unique case (frame_addr)
        ADDR_CAL: begin
          st_next.cal = frame_data[CAL_TRIG_BIT];
        end
        ADDR_CFG: begin
          st_next.regs[IDX_CFG] = frame_data;
        end
        ADDR_OFS_A: begin
          st_next.regs[IDX_OFS_A] = frame_data;
        end
        ADDR_FS_A: begin
          st_next.regs[IDX_FS_A] = frame_data;
        end
        ADDR_EXT_CFG: begin
          st_next.regs[IDX_EXT_CFG] = frame_data;
        end
        ADDR_OFS_B: begin
          st_next.regs[IDX_OFS_B] = frame_data;
        end
        ADDR_FS_B: begin
          st_next.regs[IDX_FS_B] = frame_data;
        end
        ADDR_PH_FINE: begin
          st_next.regs[IDX_PH_FINE] = frame_data;
        end
        ADDR_PH_COARSE: begin
          st_next.regs[IDX_PH_COARSE] = frame_data;
        end
        default: begin
          // reserved address: frame accepted, nothing stored
          st_next.rsv = 1'b1;
        end
      endcase
    end
    // normal mode shows power-on values; stored contents stay for later
    st_next.eff = ext_s ? st_next.regs : REG_RST;
  end

  // single state register; power-on values give ddr and 1:2 demux
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg.sclk_prev <= 1'b1;
      st_reg.shift <= 32'h0000_0000;
      st_reg.cnt <= 5'h00;
      st_reg.regs <= REG_RST;
      st_reg.eff <= REG_RST;
      st_reg.wr <= 1'b0;
      st_reg.cal <= 1'b0;
      st_reg.hdr_err <= 1'b0;
      st_reg.rsv <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign o_cfg = st_reg.eff[IDX_CFG];
  assign o_ofs_a = st_reg.eff[IDX_OFS_A];
  assign o_fs_a = st_reg.eff[IDX_FS_A];
  assign o_ext_cfg = st_reg.eff[IDX_EXT_CFG];
  assign o_ofs_b = st_reg.eff[IDX_OFS_B];
  assign o_fs_b = st_reg.eff[IDX_FS_B];
  assign o_ph_fine = st_reg.eff[IDX_PH_FINE];
  assign o_ph_coarse = st_reg.eff[IDX_PH_COARSE];
  assign o_cal_start = st_reg.cal;
  assign o_wr_done = st_reg.wr;
  assign o_hdr_err = st_reg.hdr_err;
  assign o_rsv_addr = st_reg.rsv;

  // checks on the framing and storage
  AST_IGNORE_NORMAL: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !ext_s |=> (st_reg.cnt == 5'h00) && !st_reg.wr && !st_reg.cal)
    else $error("serial pins acted on outside extended mode");

  AST_SAMPLE_RISE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && rise) |=> (st_reg.shift[0] == $past(sd_s))
      && (st_reg.shift[31:1] == $past(st_reg.shift[30:0])))
    else $error("data not shifted on serial clock rise");

  AST_COUNT_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && !rise) |=> $stable(st_reg.cnt) && $stable(st_reg.shift))
    else $error("bit count moved without a serial clock rise");

  AST_HEADER_GATE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.wr |-> $past(frame_done) && ($past(st_reg.shift[30:19]) == FRAME_HDR))
    else $error("write taken without the fixed header");

  AST_STORE_CFG: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (frame_ok && frame_addr == ADDR_CFG) |=> (st_reg.regs[IDX_CFG] == $past(frame_data)))
    else $error("configuration word not stored");

  AST_NEXT_FRAME: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    frame_done |=> (st_reg.cnt == 5'h00))
    else $error("count did not restart after the 32nd bit");

  AST_ABORT_PARTIAL: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (scs_n_s && st_reg.cnt != 5'h00) |=> (st_reg.cnt == 5'h00) ##1 !st_reg.wr)
    else $error("partial frame not discarded");

  AST_CAL_PULSE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.cal |-> $past(frame_ok && frame_addr == ADDR_CAL) ##1 !st_reg.cal)
    else $error("calibration start not a single-cycle answer to bit 15");

  AST_RESERVED: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (frame_ok && (frame_addr == 4'h4 || frame_addr == 4'hc)) |=> $stable(st_reg.regs))
    else $error("reserved address changed a register");

  AST_NORMAL_DEFAULT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !ext_s |=> (st_reg.eff == REG_RST))
    else $error("configuration visible in normal mode");

  // pulse and storage checks; pulses are compared with the frame that caused them
  AST_HDR_ERR_CAUSE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.hdr_err |-> $past(frame_done) && ($past(st_reg.shift[30:19]) != FRAME_HDR))
    else $error("header error flagged on a good header");

  // a bad header must never reach the store
  AST_BAD_HDR_NO_STORE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (frame_done && !frame_ok) |=> $stable(st_reg.regs))
    else $error("frame with a bad header changed a register");

  AST_PULSE_EXCL: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.hdr_err |-> !st_reg.wr && !st_reg.cal && !st_reg.rsv)
    else $error("header error pulse together with a write pulse");

  AST_SHORT_NO_WRITE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && rise && (st_reg.cnt != LAST_BIT_IDX)) |=> !st_reg.wr && !st_reg.hdr_err)
    else $error("frame answered before its 32nd bit");

  AST_STORE_EXT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (frame_ok && frame_addr == ADDR_EXT_CFG)
      |=> (st_reg.regs[IDX_EXT_CFG] == $past(frame_data)))
    else $error("extended configuration word not stored");

  AST_STORE_COARSE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (frame_ok && frame_addr == ADDR_PH_COARSE)
      |=> (st_reg.regs[IDX_PH_COARSE] == $past(frame_data)))
    else $error("coarse phase word not stored");

  AST_RSV_PULSE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.rsv |-> st_reg.wr && !st_reg.cal)
    else $error("reserved address pulse without an accepted frame");

  AST_CAL_NO_STORE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (frame_ok && frame_addr == ADDR_CAL) |=> $stable(st_reg.regs))
    else $error("calibration write changed a held register");

  // the usual first write carries 7fff, which must not start a calibration
  AST_CAL_BIT_ZERO: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (frame_ok && frame_addr == ADDR_CAL && !frame_data[CAL_TRIG_BIT]) |=> !st_reg.cal)
    else $error("calibration started with the trigger bit clear");

  // contents move only on an accepted frame; power-down has no path into them
  AST_REGS_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !frame_ok |=> $stable(st_reg.regs))
    else $error("register changed without an accepted frame");

  AST_EXT_VISIBLE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ext_s |=> (st_reg.eff == st_reg.regs))
    else $error("stored configuration not shown in extended mode");

  // main scenarios
  COV_WRITE: cover property (@(posedge i_clk) disable iff (!i_rst_n) st_reg.wr);
  COV_CAL: cover property (@(posedge i_clk) disable iff (!i_rst_n) st_reg.cal);
  COV_BACK_TO_BACK: cover property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_reg.wr ##[1:400] st_reg.wr);
  COV_BAD_HDR: cover property (@(posedge i_clk) disable iff (!i_rst_n) st_reg.hdr_err);
  COV_PARTIAL_DROP: cover property (
    @(posedge i_clk) disable iff (!i_rst_n)
    scs_n_s && (st_reg.cnt != 5'h00));

endmodule

// File: testbench/scwp_host.sv
`timescale 1ns/1ps

module scwp_host (
  // system clock paces the host
  input wire logic i_clk,
  // serial pins towards the port
  output logic o_serial_clk,
  output logic o_serial_in_line,
  output logic o_serial_select_n
);
  // idle: serial clock parked, select high
  initial begin
    o_serial_clk = 1'b0;
    o_serial_in_line = 1'b0;
    o_serial_select_n = 1'b1;
  end

  // top nbits of word, msb first, 800 ns bit time; select stays low after
  task automatic send(input logic [31:0] word, input int nbits);
    if (o_serial_select_n) begin
      @(posedge i_clk) o_serial_select_n <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    for (int i = 0; i < nbits; i++) begin
      @(posedge i_clk) begin
        o_serial_clk <= 1'b0;
        o_serial_in_line <= word[31-i];
      end
      repeat (3) @(posedge i_clk);
      @(posedge i_clk) o_serial_clk <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
    // data hold over: flip it so a stale bit is never mistaken for a good one
    @(posedge i_clk) begin
      o_serial_clk <= 1'b0;
      o_serial_in_line <= ~o_serial_in_line;
    end
  endtask

  // select held low between frames is allowed, so release is separate
  task automatic release_sel();
    @(posedge i_clk) o_serial_select_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module tb;
  import scwp_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ext_mode = 1'b0;
  logic sclk, sdin, ssel_n;
  logic [15:0] o_cfg, o_ofs_a, o_fs_a, o_ext_cfg, o_ofs_b, o_fs_b, o_ph_fine, o_ph_coarse;
  logic o_cal_start, o_wr_done, o_hdr_err, o_rsv_addr;
  int fails = 0;
  int check_count = 0;
  int seed = 18179;
  int n_wr = 0, n_hdr = 0, n_rsv = 0, n_cal = 0;
  logic [15:0] exp_r [16];
  logic [3:0] adrs [8] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};
  logic [3:0] rsv [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc, 4'hd};

  always #50 i_clk = ~i_clk;

  scwp_host host (.i_clk(i_clk), .o_serial_clk(sclk), .o_serial_in_line(sdin),
    .o_serial_select_n(ssel_n));

  scwp_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ext_mode(i_ext_mode),
    .i_serial_clk(sclk), .i_serial_in_line(sdin), .i_serial_select_n(ssel_n),
    .o_cfg(o_cfg), .o_ofs_a(o_ofs_a), .o_fs_a(o_fs_a), .o_ext_cfg(o_ext_cfg),
    .o_ofs_b(o_ofs_b), .o_fs_b(o_fs_b), .o_ph_fine(o_ph_fine), .o_ph_coarse(o_ph_coarse),
    .o_cal_start(o_cal_start), .o_wr_done(o_wr_done), .o_hdr_err(o_hdr_err),
    .o_rsv_addr(o_rsv_addr));

  // pulse tallies, compared as differences around each frame
  always @(posedge i_clk) begin
    n_wr <= n_wr + int'(o_wr_done === 1'b1);
    n_hdr <= n_hdr + int'(o_hdr_err === 1'b1);
    n_rsv <= n_rsv + int'(o_rsv_addr === 1'b1);
    n_cal <= n_cal + int'(o_cal_start === 1'b1);
  end

  function automatic logic [15:0] rst_val(input logic [3:0] a);
    if (a == 4'h1) return 16'hb2ff;
    if (a inside {4'h2, 4'h3, 4'ha, 4'hb}) return 16'h8000;
    return 16'h0000;
  endfunction

  function automatic logic [15:0] outv(input logic [3:0] a);
    case (a)
      4'h1: return o_cfg;
      4'h2: return o_ofs_a;
      4'h3: return o_fs_a;
      4'h9: return o_ext_cfg;
      4'ha: return o_ofs_b;
      4'hb: return o_fs_b;
      4'he: return o_ph_fine;
      default: return o_ph_coarse;
    endcase
  endfunction

  task automatic check_regs();
    foreach (adrs[i]) begin
      `CHK(outv(adrs[i]), i_ext_mode ? exp_r[adrs[i]] : rst_val(adrs[i]))
    end
  endtask

  // one frame; a short one is cut off by raising select
  task automatic xfer(input logic [11:0] h, input logic [3:0] a, input logic [15:0] d,
      input int nb);
    int w0, h0, r0, c0;
    logic acc, ok, isreg;
    w0 = n_wr;
    h0 = n_hdr;
    r0 = n_rsv;
    c0 = n_cal;
    host.send({h, a, d}, nb);
    if (nb < 32) host.release_sel();
    repeat (6) @(posedge i_clk);
    acc = i_ext_mode && nb == 32;
    ok = acc && h == 12'h001;
    isreg = a inside {adrs};
    if (ok && isreg) exp_r[a] = d;
    `CHK(n_wr - w0, int'(ok))
    `CHK(n_hdr - h0, int'(acc && !ok))
    `CHK(n_rsv - r0, int'(ok && !isreg && a != 4'h0))
    `CHK(n_cal - c0, int'(ok && a == 4'h0 && d[15]))
    check_regs();
  endtask

  task automatic done(input string name);
    $display("test %s finished, checks %0d", name, check_count);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: about 40 frames of some 270 cycles fit well inside this span
  initial begin
    repeat (40000) @(posedge i_clk);
    fails++;
    end_of_test();
  end

  initial begin
    logic [11:0] h;
    logic [3:0] a;
    foreach (exp_r[i]) exp_r[i] = rst_val(4'(i));
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    check_regs();
    `CHK(o_cal_start, 1'b0)
    done("reset");
    xfer(12'h001, 4'h1, 16'h1234, 32);
    host.release_sel();
    @(posedge i_clk) i_ext_mode <= 1'b1;
    repeat (4) @(posedge i_clk);
    check_regs();
    done("normal mode");
    // first session: all nine, back to back, select kept low
    xfer(12'h001, 4'h0, 16'h7fff, 32);
    foreach (adrs[i]) xfer(12'h001, adrs[i], 16'($random(seed)), 32);
    host.release_sel();
    done("initial session");
    foreach (rsv[i]) xfer(12'h001, rsv[i], 16'($random(seed)), 32);
    done("reserved");
    repeat (6) begin
      h = 12'($random(seed));
      if (h == 12'h001) h = 12'h801;
      a = adrs[3'($random(seed))];
      xfer(h, a, 16'($random(seed)), 32);
      xfer(12'h001, a, 16'($random(seed)), 1 + ($unsigned($random(seed)) % 31));
      xfer(12'h001, a, 16'($random(seed)), 32);
    end
    host.release_sel();
    done("header and partial");
    xfer(12'h001, 4'h0, 16'hffff, 32);
    repeat (50) @(posedge i_clk);
    done("calibration");
    @(posedge i_clk) i_ext_mode <= 1'b0;
    repeat (4) @(posedge i_clk);
    check_regs();
    @(posedge i_clk) i_ext_mode <= 1'b1;
    repeat (4) @(posedge i_clk);
    check_regs();
    done("mode change");
    end_of_test();
  end
endmodule
